// ### rtl/pfc_top.v
// Port 2 flow-control configuration and status register, APB slave.
// Assumes APB master on CLK_SYS_I; negotiation results come from logic on
// the same clock; configuration straps come from pins.
//
// Function
// - Bit 6 backpressure enable, read/write
// - Bit 5 reports duplex, 1 half
// - Bit 4 reports receive pause active
// - Bit 3 reports transmit pause active
// - Bit 2 receive pause enable, used when manual or negotiation off
// - Bit 1 transmit pause enable, used when manual or negotiation off
// - Manual 0, negotiation on: use negotiation
// - Manual 0, negotiation off: use enables
// - Manual 1: enables decide in full duplex
// - Writes never touch PHY advertisement
// - Backpressure enable loads from its strap
// - Status bits start from several straps
// - Both pause enables load from strap
// - Manual select loads from its strap
`timescale 1ns/10ps
`default_nettype none
`include "pfc_map.vh"

module pfc_top (
    input  wire        CLK_SYS_I,
    input  wire        RSTN_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    input  wire [3:0]  PSTRB_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // Configuration straps (pins)
    input  wire        P2_BACKPRESSURE_STRAP_I,
    input  wire        P2_FULL_DUPLEX_PAUSE_STRAP_I,
    input  wire        P2_MANUAL_SELECT_STRAP_I,
    input  wire        P2_ANEG_STRAP_I,
    input  wire        P2_HALF_DUPLEX_STRAP_I,
    // Port state from the MAC/negotiation logic
    input  wire        P2_ANEG_ENABLE_I,
    input  wire        P2_HALF_DUPLEX_I,
    input  wire        P2_ANEG_RX_PAUSE_I,
    input  wire        P2_ANEG_TX_PAUSE_I,
    // Controls towards the port
    output reg         P2_BACKPRESSURE_ON_O,
    output reg         P2_RX_PAUSE_ACTIVE_O,
    output reg         P2_TX_PAUSE_ACTIVE_O,
    output reg         P2_DUPLEX_NOW_O
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_LOAD = 1'b0; // Waiting for straps
    localparam ST_RUN  = 1'b1; // Normal operation

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg                   rst_s1_reg;
    reg                   rst_s2_reg;
    wire                  rst_n;
    wire                  bp_strap;
    wire                  fd_strap;
    wire                  man_strap;
    wire                  an_strap;
    wire                  hd_strap;
    reg                   state_reg;
    reg                   state_next;
    reg  [`PFC_CNT_W-1:0] cnt_reg;
    reg  [`PFC_CNT_W-1:0] cnt_next;
    reg                   load_now;
    reg                   bp_on_reg;
    reg                   bp_on_next;
    reg                   rx_en_reg;
    reg                   rx_en_next;
    reg                   tx_en_reg;
    reg                   tx_en_next;
    reg                   manual_reg;
    reg                   manual_next;
    reg  [2:0]            stat_next;
    wire                  hit;
    wire                  access;
    wire                  wr_take;
    reg  [31:0]           rd_word;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Resolve {duplex, rx active, tx active}
    function [2:0] resolve;
        input manual;
        input aneg_en;
        input half;
        input rx_en;
        input tx_en;
        input an_rx;
        input an_tx;
        begin
            if (half) begin
                // Pause frames exist only in full duplex
                resolve = 3'h4;
            end else if (manual || !aneg_en) begin
                resolve = {1'b0, rx_en, tx_en};
            end else begin
                resolve = {1'b0, an_rx, an_tx};
            end
        end
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Two-stage release of the external reset
    always @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_reg <= 1'h0;
            rst_s2_reg <= 1'h0;
        end else begin
            rst_s1_reg <= 1'h1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign rst_n = rst_s2_reg;

    // ----------------------------------------
    // Strap synchronisers
    // ----------------------------------------
    pfc_sync3 u_sync_bp (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .d_i     (P2_BACKPRESSURE_STRAP_I),
        .q_o     (bp_strap)
    );

    pfc_sync3 u_sync_fd (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .d_i     (P2_FULL_DUPLEX_PAUSE_STRAP_I),
        .q_o     (fd_strap)
    );

    pfc_sync3 u_sync_man (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .d_i     (P2_MANUAL_SELECT_STRAP_I),
        .q_o     (man_strap)
    );

    pfc_sync3 u_sync_an (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .d_i     (P2_ANEG_STRAP_I),
        .q_o     (an_strap)
    );

    pfc_sync3 u_sync_hd (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .d_i     (P2_HALF_DUPLEX_STRAP_I),
        .q_o     (hd_strap)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Access phase, register hit, write commit
    assign access  = PSEL_I & PENABLE_I & (state_reg == ST_RUN);
    assign hit     = (PADDR_I == `PFC_OFS_P2_FC);
    // Write lands on the edge that samples PREADY high
    assign wr_take = access & PREADY_O & PWRITE_I & hit & PSTRB_I[0];

    // ----------------------------------------
    // Read data assembly
    // ----------------------------------------
    // reserved bits zero
    always @* begin
        rd_word = `PFC_RST_DATA;
        rd_word[`PFC_BIT_DUPLEX] = P2_DUPLEX_NOW_O;
        rd_word[`PFC_BIT_RX_ACT] = P2_RX_PAUSE_ACTIVE_O;
        rd_word[`PFC_BIT_TX_ACT] = P2_TX_PAUSE_ACTIVE_O;
        rd_word[`PFC_BIT_BP_ON]  = bp_on_reg;
        rd_word[`PFC_BIT_RX_EN]  = rx_en_reg;
        rd_word[`PFC_BIT_TX_EN]  = tx_en_reg;
        rd_word[`PFC_BIT_MANUAL] = manual_reg;
    end

    // ----------------------------------------
    // Load sequencer
    // ----------------------------------------
    // Waits out the strap chains, then runs for good
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        load_now   = 1'b0;
        case (state_reg)
            ST_LOAD: begin
                if (cnt_reg == `PFC_LOAD_CYC) begin
                    state_next = ST_RUN;
                    load_now   = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_LOAD;
                cnt_next   = {`PFC_CNT_W{1'b0}};
            end
        endcase
    end

    // ----------------------------------------
    // Control field next values
    // ----------------------------------------
    // Straps once at load, software writes after
    always @* begin
        bp_on_next  = bp_on_reg;
        rx_en_next  = rx_en_reg;
        tx_en_next  = tx_en_reg;
        manual_next = manual_reg;
        if (load_now) begin
            bp_on_next  = bp_strap;
            rx_en_next  = fd_strap;
            tx_en_next  = fd_strap;
            manual_next = man_strap;
        end else if (wr_take) begin
            bp_on_next  = PWDATA_I[`PFC_BIT_BP_ON];
            rx_en_next  = PWDATA_I[`PFC_BIT_RX_EN];
            tx_en_next  = PWDATA_I[`PFC_BIT_TX_EN];
            manual_next = PWDATA_I[`PFC_BIT_MANUAL];
        end
    end

    // ----------------------------------------
    // Status resolution
    // ----------------------------------------
    // Strap view at load, live port view while running
    always @* begin
        stat_next = {P2_DUPLEX_NOW_O, P2_RX_PAUSE_ACTIVE_O,
                     P2_TX_PAUSE_ACTIVE_O};
        if (load_now) begin
            stat_next = resolve(man_strap, an_strap, hd_strap,
                                fd_strap, fd_strap,
                                fd_strap, fd_strap);
        end else if (state_reg == ST_RUN) begin
            stat_next = resolve(manual_reg, P2_ANEG_ENABLE_I,
                                P2_HALF_DUPLEX_I, rx_en_reg,
                                tx_en_reg, P2_ANEG_RX_PAUSE_I,
                                P2_ANEG_TX_PAUSE_I);
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // no path to advertisement
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_LOAD;
            cnt_reg    <= {`PFC_CNT_W{1'b0}};
            bp_on_reg  <= `PFC_RST_CTRL;
            rx_en_reg  <= `PFC_RST_CTRL;
            tx_en_reg  <= `PFC_RST_CTRL;
            manual_reg <= `PFC_RST_CTRL;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            bp_on_reg  <= bp_on_next;
            rx_en_reg  <= rx_en_next;
            tx_en_reg  <= tx_en_next;
            manual_reg <= manual_next;
        end
    end

    // ----------------------------------------
    // Port controls
    // ----------------------------------------
    // Registered status and enable towards the port
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            P2_DUPLEX_NOW_O      <= `PFC_RST_CTRL;
            P2_RX_PAUSE_ACTIVE_O <= `PFC_RST_CTRL;
            P2_TX_PAUSE_ACTIVE_O <= `PFC_RST_CTRL;
            P2_BACKPRESSURE_ON_O <= `PFC_RST_CTRL;
        end else begin
            P2_DUPLEX_NOW_O      <= stat_next[2];
            P2_RX_PAUSE_ACTIVE_O <= stat_next[1];
            P2_TX_PAUSE_ACTIVE_O <= stat_next[0];
            P2_BACKPRESSURE_ON_O <= bp_on_next;
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // One wait state; unmapped address flags an error
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_O  <= 1'h0;
            PSLVERR_O <= 1'h0;
        end else if (access && !PREADY_O) begin
            PREADY_O  <= 1'h1;
            PSLVERR_O <= ~hit;
        end else begin
            PREADY_O  <= 1'h0;
            PSLVERR_O <= 1'h0;
        end
    end

    // Read word stands with PREADY only, zero otherwise
    always @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA_O <= `PFC_RST_DATA;
        end else if (access && !PREADY_O && hit && !PWRITE_I) begin
            PRDATA_O <= rd_word;
        end else begin
            PRDATA_O <= `PFC_RST_DATA;
        end
    end

endmodule
`default_nettype wire

// ### rtl/pfc_map.vh
// Constants of the port 2 flow-control register block.
// Assumes inclusion by pfc_top.v; definitions only.
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PFC_ADDR_W        12
`define PFC_OFS_P2_FC     12'h1A4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFC_BIT_MANUAL    0
`define PFC_BIT_TX_EN     1
`define PFC_BIT_RX_EN     2
`define PFC_BIT_TX_ACT    3
`define PFC_BIT_RX_ACT    4
`define PFC_BIT_DUPLEX    5
`define PFC_BIT_BP_ON     6

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define PFC_RST_CTRL      1'h0
`define PFC_RST_DATA      32'h0000_0000
`define PFC_LOAD_CYC      3'h4
`define PFC_CNT_W         3

`endif

// ### rtl/pfc_sync3.v
// Three-stage synchroniser for one level from a pin.
// Assumes the level is quasi-static; output moves once stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none

module pfc_sync3 (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire d_i,
    output reg  q_o
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // ----------------------------------------
    // Capture chain
    // ----------------------------------------
    // First stage feeds only the second
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'h0;
            s2_reg <= 1'h0;
            s3_reg <= 1'h0;
            q_o    <= 1'h0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q_o <= s3_reg; // Agreed value only
            end
        end
    end

endmodule
`default_nettype wire

// ### test/pfc_top_chk.sv
// Port-level checker of the port 2 flow-control register.
// Assumes binding into pfc_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module pfc_chk (
    input wire logic        CLK_SYS_I,
    input wire logic        RSTN_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        P2_HALF_DUPLEX_I,
    input wire logic        P2_BACKPRESSURE_ON_O,
    input wire logic        P2_RX_PAUSE_ACTIVE_O,
    input wire logic        P2_TX_PAUSE_ACTIVE_O,
    input wire logic        P2_DUPLEX_NOW_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    // Settle count, covers strap load
    logic [3:0] st_reg;
    always @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I)
            st_reg <= 4'h0;
        else if (st_reg != 4'hF)
            st_reg <= st_reg + 4'h1;
    end
    wire logic ok = st_reg == 4'hF;
    // -------------------------------
    // Properties
    // -------------------------------
    sequence s_take; ok && PSEL_I && PENABLE_I && !PREADY_O; endsequence
    sequence s_ans; PREADY_O ##1 !PREADY_O; endsequence
    property p_ans; s_take |=> s_ans; endproperty
    property p_err; PREADY_O |-> PSLVERR_O == (PADDR_I != 12'h1A4); endproperty
    property p_idle; !PREADY_O |-> PRDATA_O == 32'h0; endproperty
    property p_rd; PREADY_O && !PWRITE_I && !PSLVERR_O |-> PRDATA_O[31:3] == {25'h0,
        $past(P2_BACKPRESSURE_ON_O), $past(P2_DUPLEX_NOW_O),
        $past(P2_RX_PAUSE_ACTIVE_O), $past(P2_TX_PAUSE_ACTIVE_O)}; endproperty
    property p_half; ok && $past(P2_HALF_DUPLEX_I)
        |-> !P2_RX_PAUSE_ACTIVE_O && !P2_TX_PAUSE_ACTIVE_O; endproperty
    property p_dup; ok |-> P2_DUPLEX_NOW_O == $past(P2_HALF_DUPLEX_I); endproperty
    property p_wbp; PREADY_O && PWRITE_I && !PSLVERR_O && PSTRB_I[0]
        |=> P2_BACKPRESSURE_ON_O == $past(PWDATA_I[6]); endproperty
    property p_strb; PREADY_O && PWRITE_I && !PSTRB_I[0]
        |=> $stable(P2_BACKPRESSURE_ON_O); endproperty
    a_ans: assert property (p_ans) else $error("ready not one pulse");
    a_err: assert property (p_err) else $error("bad slave error");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_rd: assert property (p_rd) else $error("read fields wrong");
    a_half: assert property (p_half) else $error("pause in half duplex");
    a_dup: assert property (p_dup) else $error("duplex wrong");
    a_wbp: assert property (p_wbp) else $error("backpressure write lost");
    a_strb: assert property (p_strb) else $error("masked write applied");
endmodule
bind pfc_top pfc_chk u_chk (.*);
`default_nettype wire

// ### test/pfc_top_tb_top.sv
// Self-checking bench of the port 2 flow-control register.
// Assumes pfc_top alone; the bench drives APB, straps and port state.
`timescale 1ns/10ps
`default_nettype none
module pfc_top_tb_top;
    logic        clk = 1'b0;
    logic        rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0]  pstrb, outs, cfg;
    logic [4:0]  strap;
    logic        half, aneg, an_rx, an_tx;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cyc = 0;
    pfc_top dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .P2_BACKPRESSURE_STRAP_I(strap[4]), .P2_FULL_DUPLEX_PAUSE_STRAP_I(strap[3]),
        .P2_MANUAL_SELECT_STRAP_I(strap[2]), .P2_ANEG_STRAP_I(strap[1]),
        .P2_HALF_DUPLEX_STRAP_I(strap[0]), .P2_ANEG_ENABLE_I(aneg),
        .P2_HALF_DUPLEX_I(half), .P2_ANEG_RX_PAUSE_I(an_rx), .P2_ANEG_TX_PAUSE_I(an_tx),
        .P2_BACKPRESSURE_ON_O(outs[3]), .P2_DUPLEX_NOW_O(outs[2]),
        .P2_RX_PAUSE_ACTIVE_O(outs[1]), .P2_TX_PAUSE_ACTIVE_O(outs[0]));
    // -------------------------------
    // Clock, guard, helpers
    // -------------------------------
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    function automatic logic [31:0] nxt();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    // Expected word: {bp, rx_en, tx_en, manual} in cfg
    function automatic logic [31:0] expw();
        logic ra;
        logic ta;
        ra = !half && ((cfg[0] || !aneg) ? cfg[2] : an_rx);
        ta = !half && ((cfg[0] || !aneg) ? cfg[1] : an_tx);
        return {25'h0, cfg[3], half, ra, ta, cfg[2:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int k;
        k = 0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk);
        if (k == 20)
            n_fail++;
    endtask
    task automatic summarize();
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // -------------------------------
    // Main sequence, two resets
    // -------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [31:0] rd;
        logic [31:0] e;
        logic [11:0] a;
        logic        er;
        rnd = 32'hC;
        {rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {strap, half, aneg, an_rx, an_tx} = '0;
        for (int p = 0; p < 2; p++) begin
            r = nxt();
            rstn <= 1'b0;
            strap <= r[4:0];
            repeat (6) @(posedge clk);
            rstn <= 1'b1;
            // Strap view of status stands one cycle after the load
            repeat (7) @(posedge clk);
            @(negedge clk);
            chk({28'h0, outs}, {28'h0, strap[4], strap[0], {2{strap[3] & ~strap[0]}}});
            repeat (9) @(posedge clk);
            cfg = {strap[4], strap[3], strap[3], strap[2]};
            apb(1'b0, 12'h1A4, 32'h0, 4'hF, rd, er);
            chk(rd, expw());
            for (int i = 0; i < 40; i++) begin
                r = nxt();
                d = nxt();
                a = (r[6:4] == 3'h0) ? {r[17:8], 2'h0} : 12'h1A4;
                if (i < 2) begin
                    a = 12'h1A4;
                    d = {32{~i[0]}};
                    r[18] = 1'b1;
                end
                {half, aneg, an_rx, an_tx} <= r[3:0];
                apb(1'b1, a, d, r[21:18], rd, er);
                if (a == 12'h1A4 && r[18])
                    cfg = {d[6], d[2:0]};
                chk({31'h0, er}, {31'h0, a != 12'h1A4});
                apb(1'b0, a, 32'h0, 4'hF, rd, er);
                chk({31'h0, er}, {31'h0, a != 12'h1A4});
                e = expw();
                chk(rd, (a == 12'h1A4) ? e : 32'h0);
                chk({28'h0, outs}, {28'h0, e[6:3]});
            end
        end
        summarize();
    end
endmodule
`default_nettype wire
